// ### verilog/stream_attr_pkg.sv
// Package: register map, field widths and carriers for the stream attribute bank
package stream_attr_pkg;
    localparam int AddrWidth = 12;
    localparam logic [11:0] OffInterlaceS3 = 12'h590;
    localparam logic [11:0] OffTuMinS3 = 12'h594;
    localparam logic [11:0] OffTuFracS3 = 12'h598;
    localparam logic [11:0] OffLineWaitS3 = 12'h59c;
    localparam logic [11:0] OffLineTotalS4 = 12'h5a0;
    localparam logic [11:0] OffFrameTotalS4 = 12'h5a4;
    localparam logic [11:0] OffPolarityS4 = 12'h5a8;
    localparam logic [11:0] OffLineSyncS4 = 12'h5ac;
    localparam logic [11:0] OffFrameSyncS4 = 12'h5b0;
    localparam logic [11:0] OffActPixS4 = 12'h5b4;
    localparam logic [11:0] OffActLinesS4 = 12'h5b8;
    localparam logic [11:0] OffLineOffsS4 = 12'h5bc;
    localparam logic [11:0] OffFrameOffsS4 = 12'h5c0;
    // Extra: transfer unit size for stream 3, framing control and status
    localparam logic [11:0] OffTuSizeS3 = 12'h580;
    localparam logic [11:0] OffFrameCtl = 12'h600;
    localparam logic [11:0] OffFrameStat = 12'h604;
    localparam int NumRegs = 16;
    localparam logic [6:0] TuSizeReset = 7'h40;
    localparam logic [31:0] ZeroWord = 32'h0000_0000;
    localparam logic [1:0] RespOkay = 2'h0;
    localparam logic [1:0] RespSlvErr = 2'h2;

    typedef struct packed {
        logic interlaced;
        logic [7:0] tuWholeFill;
        logic [9:0] tuFractionalFill;
        logic [7:0] lineWait;
        logic [6:0] tuSize;
    } s3_attr_type;

    typedef struct packed {
        logic [15:0] lineTotal;
        logic [15:0] frameTotal;
        logic frameSyncPol;
        logic lineSyncPol;
        logic [14:0] lineSyncWidth;
        logic [14:0] frameSyncWidth;
        logic [15:0] activePixelCount;
        logic [15:0] activeLines;
        logic [15:0] lineActiveOffset;
        logic [15:0] frameActiveOffset;
    } s4_attr_type;

    typedef enum logic [1:0] {
        WaitIdle = 2'b00,
        WaitCount = 2'b01,
        WaitFraming = 2'b11
    } wait_state_type;
endpackage

// ### verilog/line_start_wait.sv
// Line-start wait timer that holds framing off after each new line
`timescale 1ns/10ps
module line_start_wait (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input wire logic lineStart,
    input wire logic [7:0] waitCycles,
    // Status
    output logic framingGo,
    output logic waiting
);
    stream_attr_pkg::wait_state_type state_q;
    logic [7:0] count_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= stream_attr_pkg::WaitIdle;
            count_q <= 8'h00;
        end else if (lineStart) begin
            state_q <= stream_attr_pkg::WaitCount;
            count_q <= waitCycles;
        end else begin
            case (state_q)
                stream_attr_pkg::WaitCount: begin
                    if (count_q == 8'h00) begin
                        state_q <= stream_attr_pkg::WaitFraming;
                    end else begin
                        count_q <= count_q - 8'h01;
                    end
                end
                stream_attr_pkg::WaitFraming: state_q <= stream_attr_pkg::WaitFraming;
                default: state_q <= stream_attr_pkg::WaitIdle;
            endcase
        end
    end

    assign framingGo = (state_q == stream_attr_pkg::WaitFraming);
    assign waiting = (state_q == stream_attr_pkg::WaitCount);

    chk_wait_length: assert property (@(posedge mclk) disable iff (rst)
        (state_q == stream_attr_pkg::WaitCount && count_q == 8'h00 && !lineStart) |=> framingGo)
        else $error("framing did not start after wait");
    chk_no_early_go: assert property (@(posedge mclk) disable iff (rst)
        (lineStart && waitCycles != 8'h00) |=> !framingGo)
        else $error("framing started before wait elapsed");
    cov_wait_done: cover property (@(posedge mclk) disable iff (rst) $rose(framingGo));
endmodule // line_start_wait

// ### verilog/attr_word_mux.sv
// Read-data selector over the attribute registers
`timescale 1ns/10ps
module attr_word_mux (
    // Register image
    input wire logic [31:0] words [stream_attr_pkg::NumRegs],
    input wire logic [3:0] index,
    input wire logic hit,
    // Result
    output logic [31:0] data
);
    assign data = hit ? words[index] : stream_attr_pkg::ZeroWord;
endmodule // attr_word_mux

// ### verilog/video_stream_attribute_regs.sv
// Stream 3 tail and stream 4 timing attribute registers behind AXI4-Lite
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
// How it works
// - Whole fill byte count, eight bits
// - Wait programmed cycles at each line start
// - Line total held in sixteen bits
// - Frame total lines in sixteen bits
// - Polarity: vertical bit one, horizontal bit zero
// - Line sync width fifteen bits
// - Frame sync width fifteen bits
// - Active pixels sixteen bits
// - Active lines sixteen bits
// - Line active offset sixteen bits
// - Frame active offset sixteen bits
// - Transfer unit size resets 64, always even
module video_stream_attribute_regs (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // AXI4-Lite write
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Framing side
    input wire logic lineStart,
    output logic framingGo,
    output logic blankingInterlaced,
    output logic attrInterlaced,
    output stream_attr_pkg::s3_attr_type s3Attr,
    output stream_attr_pkg::s4_attr_type s4Attr
);
    ////////////////////////////////////////////////////////////////////////
    // Address decode
    function automatic logic [4:0] decode(input logic [11:0] a);
        case (a)
            stream_attr_pkg::OffInterlaceS3: decode = 5'h10;
            stream_attr_pkg::OffTuMinS3: decode = 5'h11;
            stream_attr_pkg::OffTuFracS3: decode = 5'h12;
            stream_attr_pkg::OffLineWaitS3: decode = 5'h13;
            stream_attr_pkg::OffLineTotalS4: decode = 5'h14;
            stream_attr_pkg::OffFrameTotalS4: decode = 5'h15;
            stream_attr_pkg::OffPolarityS4: decode = 5'h16;
            stream_attr_pkg::OffLineSyncS4: decode = 5'h17;
            stream_attr_pkg::OffFrameSyncS4: decode = 5'h18;
            stream_attr_pkg::OffActPixS4: decode = 5'h19;
            stream_attr_pkg::OffActLinesS4: decode = 5'h1a;
            stream_attr_pkg::OffLineOffsS4: decode = 5'h1b;
            stream_attr_pkg::OffFrameOffsS4: decode = 5'h1c;
            stream_attr_pkg::OffTuSizeS3: decode = 5'h1d;
            stream_attr_pkg::OffFrameCtl: decode = 5'h1e;
            stream_attr_pkg::OffFrameStat: decode = 5'h1f;
            default: decode = 5'h00;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        for (int i = 0; i < 4; i++) begin
            old[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
        merge = old;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Write channel capture
    logic awHeld_q, wHeld_q;
    logic [11:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic doWrite;
    logic [4:0] wSel;

    assign doWrite = awHeld_q && wHeld_q && !bvalid;
    assign wSel = decode(awAddr_q);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            awHeld_q <= 1'b0;
            awAddr_q <= 12'h000;
        end else if (awvalid && awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= awaddr;
        end else if (doWrite) begin
            awHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wHeld_q <= 1'b0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end else if (wvalid && wready) begin
            wHeld_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
        end else if (doWrite) begin
            wHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            awready <= 1'b0;
            wready <= 1'b0;
        end else begin
            awready <= !awHeld_q && !(awvalid && awready) && !bvalid;
            wready <= !wHeld_q && !(wvalid && wready) && !bvalid;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp <= stream_attr_pkg::RespOkay;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= (wSel[4] && wSel != 5'h1f) ? stream_attr_pkg::RespOkay : stream_attr_pkg::RespSlvErr;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register storage, one word per slot
    logic [31:0] regs_q [stream_attr_pkg::NumRegs];
    logic [31:0] image [stream_attr_pkg::NumRegs];
    logic [31:0] merged;
    logic waiting;

    assign merged = merge(regs_q[wSel[3:0]], wData_q, wStrb_q);

    genvar g;
    generate
        for (g = 0; g < stream_attr_pkg::NumRegs - 1; g++) begin : gSlot
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    regs_q[g] <= (g == 13) ? {25'h0, stream_attr_pkg::TuSizeReset} : 32'h0000_0000;
                end else if (doWrite && wSel == {1'b1, 4'(g)}) begin
                    regs_q[g] <= merged;
                end
            end
        end
    endgenerate

    // Status word is live state, not storage
    assign regs_q[15] = {30'h0, framingGo, waiting};

    assign image[0] = {31'h0, regs_q[0][0]};
    assign image[1] = {24'h0, regs_q[1][7:0]};
    assign image[2] = {22'h0, regs_q[2][9:0]};
    assign image[3] = {24'h0, regs_q[3][7:0]};
    assign image[4] = {16'h0, regs_q[4][15:0]};
    assign image[5] = {16'h0, regs_q[5][15:0]};
    assign image[6] = {30'h0, regs_q[6][1:0]};
    assign image[7] = {17'h0, regs_q[7][14:0]};
    assign image[8] = {17'h0, regs_q[8][14:0]};
    assign image[9] = {16'h0, regs_q[9][15:0]};
    assign image[10] = {16'h0, regs_q[10][15:0]};
    assign image[11] = {16'h0, regs_q[11][15:0]};
    assign image[12] = {16'h0, regs_q[12][15:0]};
    assign image[13] = {25'h0, regs_q[13][6:1], 1'b0};
    assign image[14] = {31'h0, regs_q[14][0]};
    assign image[15] = regs_q[15];

    ////////////////////////////////////////////////////////////////////////
    // Read channel
    logic [4:0] rSel;
    logic [31:0] rWord;
    assign rSel = decode(araddr);

    attr_word_mux uMux (
        .words(image),
        .index(rSel[3:0]),
        .hit(rSel[4]),
        .data(rWord)
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            arready <= 1'b0;
        end else begin
            arready <= !rvalid && !(arvalid && arready);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= stream_attr_pkg::RespOkay;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rWord;
            rresp <= rSel[4] ? stream_attr_pkg::RespOkay : stream_attr_pkg::RespSlvErr;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Attribute outputs, registered
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s3Attr <= '0;
            s4Attr <= '0;
            blankingInterlaced <= 1'b0;
            attrInterlaced <= 1'b0;
        end else begin
            blankingInterlaced <= image[0][0];
            attrInterlaced <= image[0][0];
            s3Attr <= {image[0][0], image[1][7:0], image[2][9:0], image[3][7:0], image[13][6:0]};
            s4Attr <= {image[4][15:0], image[5][15:0], image[6][1], image[6][0], image[7][14:0],
                image[8][14:0], image[9][15:0], image[10][15:0], image[11][15:0], image[12][15:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Line-start wait, enabled by control bit
    logic goRaw;
    line_start_wait uWait (
        .mclk(mclk),
        .rst(rst),
        .lineStart(lineStart && image[14][0]),
        .waitCycles(image[3][7:0]),
        .framingGo(goRaw),
        .waiting(waiting)
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            framingGo <= 1'b0;
        end else begin
            framingGo <= goRaw;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_write_readback: assert property (@(posedge mclk) disable iff (rst)
        (doWrite && wSel == 5'h14 && wStrb_q == 4'hf) |=> (regs_q[4] == $past(wData_q)))
        else $error("written word not stored");
    chk_interlace_out: assert property (@(posedge mclk) disable iff (rst)
        ##1 (blankingInterlaced == $past(regs_q[0][0]) && attrInterlaced == blankingInterlaced))
        else $error("interlace mark wrong");
    chk_size_even: assert property (@(posedge mclk) disable iff (rst) image[13][0] == 1'b0)
        else $error("transfer unit size odd");
    chk_polarity_map: assert property (@(posedge mclk) disable iff (rst)
        ##1 (s4Attr.frameSyncPol == $past(regs_q[6][1]) && s4Attr.lineSyncPol == $past(regs_q[6][0])))
        else $error("polarity bits swapped");
    chk_width_mask: assert property (@(posedge mclk) disable iff (rst)
        image[7][31:15] == 17'h0 && image[8][31:15] == 17'h0)
        else $error("sync width too wide");
    chk_total_mask: assert property (@(posedge mclk) disable iff (rst)
        image[4][31:16] == 16'h0 && image[5][31:16] == 16'h0)
        else $error("total register too wide");
    chk_fill_fields: assert property (@(posedge mclk) disable iff (rst)
        ##1 (s3Attr.tuWholeFill == $past(regs_q[1][7:0]) && s3Attr.tuFractionalFill == $past(regs_q[2][9:0])))
        else $error("fill values not forwarded");
    chk_read_answer: assert property (@(posedge mclk) disable iff (rst)
        (arvalid && arready) |=> rvalid ##0 rdata == $past(rWord))
        else $error("read answer wrong");
    chk_status_refused: assert property (@(posedge mclk) disable iff (rst)
        (doWrite && wSel == 5'h1f) |=> (bvalid && bresp == stream_attr_pkg::RespSlvErr))
        else $error("status write accepted");
    chk_write_quiet: assert property (@(posedge mclk) disable iff (rst)
        bvalid |-> (!awready && !wready))
        else $error("write ready while response pending");
    chk_read_quiet: assert property (@(posedge mclk) disable iff (rst)
        rvalid |-> !arready)
        else $error("read ready while response pending");
    chk_unmapped_read: assert property (@(posedge mclk) disable iff (rst)
        (arvalid && arready && !rSel[4]) |=> (rdata == stream_attr_pkg::ZeroWord && rresp == stream_attr_pkg::RespSlvErr))
        else $error("unmapped read not refused");
    cov_refused: cover property (@(posedge mclk) disable iff (rst) bvalid && bresp == stream_attr_pkg::RespSlvErr);
    cov_write: cover property (@(posedge mclk) disable iff (rst) bvalid && bready);
    cov_read: cover property (@(posedge mclk) disable iff (rst) rvalid && rready);
    cov_frame: cover property (@(posedge mclk) disable iff (rst) $rose(framingGo));
endmodule // video_stream_attribute_regs

// ### sim/video_stream_attribute_regs_tb.sv
// Self-checking testbench for the stream attribute register bank
`timescale 1ns/10ps
module video_stream_attribute_regs_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] awaddr = 12'h000;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [11:0] araddr = 12'h000;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic lineStart = 1'b0;
    logic framingGo;
    logic blankingInterlaced;
    logic attrInterlaced;
    stream_attr_pkg::s3_attr_type s3Attr;
    stream_attr_pkg::s4_attr_type s4Attr;
    int failures = 0;
    int compares = 0;
    int seed = 15;
    logic [31:0] expWord [15];
    logic [1:0] resp;
    logic [31:0] rd;
    // Register table: offsets and writable bits
    localparam logic [11:0] Offs [15] = '{stream_attr_pkg::OffInterlaceS3, stream_attr_pkg::OffTuMinS3,
        stream_attr_pkg::OffTuFracS3, stream_attr_pkg::OffLineWaitS3, stream_attr_pkg::OffLineTotalS4,
        stream_attr_pkg::OffFrameTotalS4, stream_attr_pkg::OffPolarityS4, stream_attr_pkg::OffLineSyncS4,
        stream_attr_pkg::OffFrameSyncS4, stream_attr_pkg::OffActPixS4, stream_attr_pkg::OffActLinesS4,
        stream_attr_pkg::OffLineOffsS4, stream_attr_pkg::OffFrameOffsS4, stream_attr_pkg::OffTuSizeS3,
        stream_attr_pkg::OffFrameCtl};
    localparam logic [31:0] Masks [15] = '{32'h0000_0001, 32'h0000_00ff, 32'h0000_03ff, 32'h0000_00ff,
        32'h0000_ffff, 32'h0000_ffff, 32'h0000_0003, 32'h0000_7fff, 32'h0000_7fff, 32'h0000_ffff,
        32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_007e, 32'h0000_0001};

    video_stream_attribute_regs DUT (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .lineStart(lineStart),
        .framingGo(framingGo), .blankingInterlaced(blankingInterlaced), .attrInterlaced(attrInterlaced),
        .s3Attr(s3Attr), .s4Attr(s4Attr));

    always #5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (failures == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // Address and data offered together, each released when taken
    task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] r);
        bit awDone;
        bit wDone;
        awDone = 0;
        wDone = 0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge mclk);
            if (!awDone && awready) begin
                awDone = 1;
                awvalid <= 1'b0;
            end
            if (!wDone && wready) begin
                wDone = 1;
                wvalid <= 1'b0;
            end
        end
        // Ready raised only once both halves are taken, so calls never toggle it in one step
        bready <= 1'b1;
        do @(posedge mclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge mclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Expected value of a masked register, bit 0 of the unit size never sticks
    function automatic logic [31:0] expectOf(input int i, input logic [31:0] d);
        return d & Masks[i];
    endfunction

    // Per-lane word count that software programs for a mode
    function automatic int laneWords(input int pixels, input int bpp, input int lanes);
        int words;
        words = (pixels * bpp + 15) / 16;
        return words + ((lanes == 1) ? 0 : words % lanes) - lanes;
    endfunction

    // line-start wait that software derives from the fill
    function automatic logic [7:0] initWait(input logic [7:0] minBytes, input logic [7:0] unitSize);
        return (minBytes <= 8'h04) ? 8'h40 : unitSize - minBytes;
    endfunction

    task automatic lineTest(input logic [7:0] n);
        int cnt;
        axiWrite(stream_attr_pkg::OffLineWaitS3, {24'h0, n}, 4'hf, resp);
        @(posedge mclk);
        lineStart <= 1'b1;
        @(posedge mclk);
        lineStart <= 1'b0;
        cnt = 0;
        do begin
            @(posedge mclk);
            #1;
            cnt++;
        end while (framingGo !== 1'b1 && cnt < 400);
        check(cnt, n + 2, "line start wait");
        repeat (3) @(posedge mclk);
        check(framingGo, 1'b1, "framing held");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        failures++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 15; i++) begin
            axiRead(Offs[i], rd, resp);
            check(rd, (i == 13) ? 32'h0000_0040 : 32'h0000_0000, "reset value");
        end
        // Random words, then all-ones and zero corners, then random words again
        for (int pass = 0; pass < 4; pass++) begin
            for (int i = 0; i < 15; i++) begin
                rd = (pass == 1) ? 32'hffff_ffff : (pass == 2) ? 32'h0000_0000 : $random(seed);
                axiWrite(Offs[i], rd, 4'hf, resp);
                check(resp, stream_attr_pkg::RespOkay, "write response");
                expWord[i] = expectOf(i, rd);
            end
            for (int i = 0; i < 15; i++) begin
                axiRead(Offs[i], rd, resp);
                check(rd, expWord[i], "read back");
            end
            @(posedge mclk);
            #1;
            check(s3Attr.tuWholeFill, expWord[1], "whole fill field");
            check(s3Attr.tuFractionalFill, expWord[2], "fraction field");
            check(s3Attr.lineWait, expWord[3], "wait field");
            check(s3Attr.tuSize, expWord[13], "unit size field");
            check(s4Attr.lineTotal, expWord[4], "line total");
            check(s4Attr.frameTotal, expWord[5], "frame total");
            check({s4Attr.frameSyncPol, s4Attr.lineSyncPol}, expWord[6], "polarity");
            check(s4Attr.lineSyncWidth, expWord[7], "line sync width");
            check(s4Attr.frameSyncWidth, expWord[8], "frame sync width");
            check(s4Attr.activePixelCount, expWord[9], "active pixels");
            check(s4Attr.activeLines, expWord[10], "active lines");
            check(s4Attr.lineActiveOffset, expWord[11], "line offset");
            check(s4Attr.frameActiveOffset, expWord[12], "frame offset");
            check({blankingInterlaced, attrInterlaced, s3Attr.interlaced}, {3{expWord[0][0]}}, "interlace marks");
            @(posedge mclk);
        end
        // Byte lanes: only lane 1 of the line total changes
        axiWrite(stream_attr_pkg::OffLineTotalS4, 32'h1234_abcd, 4'h2, resp);
        axiRead(stream_attr_pkg::OffLineTotalS4, rd, resp);
        check(rd, {16'h0, 8'hab, expWord[4][7:0]}, "byte lane write");
        // Refused places: unmapped word and read-only status
        axiWrite(12'h7fc, 32'hffff_ffff, 4'hf, resp);
        check(resp, stream_attr_pkg::RespSlvErr, "unmapped write");
        axiRead(12'h7fc, rd, resp);
        check(rd, stream_attr_pkg::ZeroWord, "unmapped read data");
        check(resp, stream_attr_pkg::RespSlvErr, "unmapped read response");
        axiWrite(stream_attr_pkg::OffFrameStat, 32'h0000_0003, 4'hf, resp);
        check(resp, stream_attr_pkg::RespSlvErr, "status write");
        // Interlaced source: software raises the flag
        axiWrite(stream_attr_pkg::OffInterlaceS3, 32'h0000_0001, 4'hf, resp);
        repeat (2) @(posedge mclk);
        check({blankingInterlaced, attrInterlaced, s3Attr.interlaced}, 3'b111, "interlaced source");
        // Software word counts for a three-pixel, 24-bit line
        check(laneWords(3, 24, 1), 32'h0000_0004, "one-lane word count");
        check(laneWords(3, 24, 2), 32'h0000_0004, "two-lane word count");
        check(laneWords(3, 24, 4), 32'h0000_0002, "four-lane word count");
        axiWrite(stream_attr_pkg::OffFrameCtl, 32'h0000_0001, 4'hf, resp);
        lineTest(8'h00);
        lineTest(initWait(8'h04, 8'h40));
        lineTest(initWait(8'h20 + 8'($unsigned($random(seed)) % 30), 8'h40));
        axiRead(stream_attr_pkg::OffFrameStat, rd, resp);
        check(rd[1:0], 2'b10, "status after wait");
        summarize();
    end
endmodule // video_stream_attribute_regs_tb
